// ### rtl/sbs_pkg.sv
package sbs_pkg;

  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned MS_PER_UNIT10  = 10;
  localparam int unsigned MS_CYCLES_DEF  = CLK_HZ / 1000;

  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_ZCLAMP     = 8'h04;
  localparam logic [7:0] ADDR_ROT_TH     = 8'h08;
  localparam logic [7:0] ADDR_OVF_LIM    = 8'h0c;
  localparam logic [7:0] ADDR_SON_WAIT   = 8'h10;
  localparam logic [7:0] ADDR_SOFF_WAIT  = 8'h14;
  localparam logic [7:0] ADDR_BRK_SPD    = 8'h18;
  localparam logic [7:0] ADDR_BRK_WAIT   = 8'h1c;
  localparam logic [7:0] ADDR_ALLOC1     = 8'h20;
  localparam logic [7:0] ADDR_ALLOC1_ACT = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h30;

  localparam int CTRL_SERVO_ON  = 0;
  localparam int CTRL_BRAKE_FN  = 1;

  localparam int ST_EXCITE  = 0;
  localparam int ST_BRAKE   = 1;
  localparam int ST_ROT     = 2;
  localparam int ST_ZCLAMP  = 3;
  localparam int ST_OVF     = 4;
  localparam int ST_SON     = 5;

  localparam int IRQ_OVF      = 0;
  localparam int IRQ_ROT      = 1;
  localparam int IRQ_ON_DONE  = 2;
  localparam int IRQ_OFF_DONE = 3;
  localparam int IRQ_BITS     = 4;

  localparam logic [31:0] RST_ZCLAMP    = 32'h0000_000a;
  localparam logic [31:0] RST_ROT_TH    = 32'h0000_0014;
  localparam logic [31:0] MAX_ROT_TH    = 32'h0000_0bb8;
  localparam logic [31:0] RST_OVF_LIM   = 32'h0000_0001;
  localparam logic [31:0] MIN_OVF_LIM   = 32'h0000_0001;
  localparam logic [31:0] MAX_OVF_LIM   = 32'h0500_0000;
  localparam logic [31:0] MAX_SON_WAIT  = 32'h0000_07d0;
  localparam logic [31:0] MAX_SOFF_WAIT = 32'h0000_01f4;
  localparam logic [31:0] MIN_BRK_SPD   = 32'h0000_000a;
  localparam logic [31:0] MAX_BRK_SPD   = 32'h0000_0064;
  localparam logic [31:0] RST_BRK_SPD   = 32'h0000_0064;
  localparam logic [31:0] MIN_BRK_WAIT  = 32'h0000_000a;
  localparam logic [31:0] MAX_BRK_WAIT  = 32'h0000_0064;
  localparam logic [31:0] RST_BRK_WAIT  = 32'h0000_0032;
  localparam logic [31:0] RST_ALLOC1    = 32'h0302_0100;
  localparam logic [7:0]  MAX_FUNC_CODE = 8'h1c;
  localparam logic [7:0]  FUNC_SERVO_ON = 8'h00;

  typedef enum logic [2:0] {
    SEQ_OFF      = 3'b000,
    SEQ_ON_BRK   = 3'b001,
    SEQ_ON_EXC   = 3'b010,
    SEQ_RUN      = 3'b011,
    SEQ_OFF_WAIT = 3'b100,
    SEQ_OFF_EXC  = 3'b101
  } sbs_seq_e;

endpackage

// ### rtl/sbs_servo_brake_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Lock position when speed command below clamp
// RULE2: Rotation output high above threshold 0..3000
// RULE3: Alarm when deviation exceeds overflow limit
// RULE4: Brake timings only when brake function assigned
// RULE5: Positive wait: brake output, wait, excite
// RULE6: Negative wait: excite, wait, brake output
// RULE7: Servo-off wait between brake and de-excitation
// RULE8: Brake acts when speed below brake threshold
// RULE9: Brake acts on wait timeout, first wins
// RULE10: Allocation word: four codes, applied at restart; code: reset also restores the staged word, so only RST_ALLOC1 is ever applied
// RULE11: Rotation output drops when speed not above
module sbs_servo_brake_sequencer
  import sbs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic      [31:0]        regRdata,
  input  wire logic [3:0]         inputPorts,
  input  wire logic signed [15:0] speedCommand,
  input  wire logic [15:0]        motorSpeed,
  input  wire logic signed [31:0] positionDeviation,
  output logic                    motorExcite,
  output logic                    holding_brake_out,
  output logic                    rotation_detect_out,
  output logic                    zeroClampActive,
  output logic                    overflowAlarm,
  output logic      [31:0]        activeAllocation,
  output logic                    irq
);

  generate
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  function automatic logic [31:0] clampVal(input logic [31:0] v, input logic [31:0] lo,
                                           input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [31:0] absVal(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [7:0] codeSat(input logic [7:0] c);
    return (c > MAX_FUNC_CODE) ? MAX_FUNC_CODE : c;
  endfunction

  logic [1:0]         ctrl_q;
  logic [15:0]        zeroClamp_q;
  logic [15:0]        rotThresh_q;
  logic [31:0]        ovfLimit_q;
  logic signed [15:0] servoOnWait_q;
  logic [15:0]        servoOffWait_q;
  logic [15:0]        brakeSpeed_q;
  logic [15:0]        brakeWait_q;
  logic [31:0]        allocStaged_q;
  logic [31:0]        allocActive_q;
  logic               allocLoaded_q;
  logic [IRQ_BITS-1:0] irqStat_q;
  logic [IRQ_BITS-1:0] irqMask_q;
  logic [31:0]        rdata_q;
  logic [31:0]        msDiv_q;
  logic               msTick;
  logic [15:0]        timer_q;
  sbs_seq_e           seq_q;
  sbs_seq_e           seqPrev_q;
  logic               excite_q;
  logic               brake_q;
  logic               rot_q;
  logic               zclamp_q;
  logic               ovf_q;
  logic               portServoOn;
  logic               servoOn;
  logic [15:0]        onWaitMag;
  logic [IRQ_BITS-1:0] irqEvents;

  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q         <= 2'h0;
      zeroClamp_q    <= RST_ZCLAMP[15:0];
      rotThresh_q    <= RST_ROT_TH[15:0];
      ovfLimit_q     <= RST_OVF_LIM;
      servoOnWait_q  <= 16'sh0000;
      servoOffWait_q <= 16'h0000;
      brakeSpeed_q   <= RST_BRK_SPD[15:0];
      brakeWait_q    <= RST_BRK_WAIT[15:0];
      allocStaged_q  <= RST_ALLOC1;
      irqMask_q      <= '0;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_CTRL:      ctrl_q        <= regWdata[1:0];
        ADDR_ZCLAMP:    zeroClamp_q   <= 16'(clampVal(regWdata, 32'h0,
                                                      MAX_ROT_TH)); // [RULE1]
        ADDR_ROT_TH:    rotThresh_q   <= 16'(clampVal(regWdata, 32'h0,
                                                      MAX_ROT_TH)); // [RULE2]
        ADDR_OVF_LIM:   ovfLimit_q    <= clampVal(regWdata, MIN_OVF_LIM, MAX_OVF_LIM);
        ADDR_SON_WAIT: begin
          if (regWdata[31]) begin
            servoOnWait_q <= -$signed(16'(clampVal(absVal(regWdata), 32'h0,
                                                   MAX_SON_WAIT))); // [RULE6]
          end else begin
            servoOnWait_q <= $signed(16'(clampVal(regWdata, 32'h0,
                                                  MAX_SON_WAIT))); // [RULE5]
          end
        end
        ADDR_SOFF_WAIT: servoOffWait_q <= 16'(clampVal(regWdata, 32'h0,
                                                       MAX_SOFF_WAIT)); // [RULE7]
        ADDR_BRK_SPD:   brakeSpeed_q  <= 16'(clampVal(regWdata, MIN_BRK_SPD,
                                                      MAX_BRK_SPD)); // [RULE8]
        ADDR_BRK_WAIT:  brakeWait_q   <= 16'(clampVal(regWdata, MIN_BRK_WAIT,
                                                      MAX_BRK_WAIT)); // [RULE9]
        ADDR_ALLOC1:    allocStaged_q <= {codeSat(regWdata[31:24]), codeSat(regWdata[23:16]),
                                          codeSat(regWdata[15:8]), codeSat(regWdata[7:0])};
        ADDR_IRQ_MASK:  irqMask_q     <= regWdata[IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
  end

  // Allocation is copied into use only once, just after restart
  always_ff @(posedge clk) begin
    if (rst) begin
      allocActive_q <= RST_ALLOC1;
      allocLoaded_q <= 1'b0;
    end else if (!allocLoaded_q) begin
      allocActive_q <= allocStaged_q; // [RULE10]
      allocLoaded_q <= 1'b1;
    end
  end

  always_comb begin
    portServoOn = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (allocActive_q[8*i +: 8] == FUNC_SERVO_ON && inputPorts[i]) begin
        portServoOn = 1'b1; // [RULE10]
      end
    end
  end

  assign servoOn   = portServoOn | ctrl_q[CTRL_SERVO_ON];
  assign onWaitMag = servoOnWait_q[15] ? 16'(-servoOnWait_q) : 16'(servoOnWait_q);

  // Millisecond enable
  always_ff @(posedge clk) begin
    if (rst || msDiv_q == MS_CYCLES - 1) begin
      msDiv_q <= 32'h0;
    end else begin
      msDiv_q <= msDiv_q + 32'h1;
    end
  end
  assign msTick = (msDiv_q == MS_CYCLES - 1);

  // Brake and excitation sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q    <= SEQ_OFF;
      timer_q  <= 16'h0;
      excite_q <= 1'b0;
      brake_q  <= 1'b0;
    end else begin
      if (msTick && timer_q != 16'h0) begin
        timer_q <= timer_q - 16'h1;
      end
      case (seq_q)
        SEQ_OFF: begin
          if (servoOn) begin
            if (!ctrl_q[CTRL_BRAKE_FN]) begin
              excite_q <= 1'b1; // [RULE4]
              seq_q    <= SEQ_RUN;
            end else if (servoOnWait_q[15]) begin
              excite_q <= 1'b1; // [RULE6]
              timer_q  <= onWaitMag;
              seq_q    <= SEQ_ON_EXC;
            end else begin
              brake_q  <= 1'b1; // [RULE5]
              timer_q  <= onWaitMag;
              seq_q    <= SEQ_ON_BRK;
            end
          end
        end
        SEQ_ON_BRK: begin
          if (!servoOn) begin
            brake_q <= 1'b0;
            seq_q   <= SEQ_OFF;
          end else if (timer_q == 16'h0) begin
            excite_q <= 1'b1; // [RULE5]
            seq_q    <= SEQ_RUN;
          end
        end
        SEQ_ON_EXC: begin
          if (!servoOn) begin
            timer_q <= 16'(brakeWait_q * MS_PER_UNIT10);
            seq_q   <= SEQ_OFF_WAIT;
          end else if (timer_q == 16'h0) begin
            brake_q <= 1'b1; // [RULE6]
            seq_q   <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (!servoOn) begin
            if (!ctrl_q[CTRL_BRAKE_FN]) begin
              excite_q <= 1'b0; // [RULE4]
              brake_q  <= 1'b0;
              seq_q    <= SEQ_OFF;
            end else begin
              timer_q <= 16'(brakeWait_q * MS_PER_UNIT10);
              seq_q   <= SEQ_OFF_WAIT;
            end
          end
        end
        SEQ_OFF_WAIT: begin
          if (motorSpeed < brakeSpeed_q || timer_q == 16'h0) begin
            brake_q <= 1'b0; // [RULE8] [RULE9]
            timer_q <= 16'(servoOffWait_q * MS_PER_UNIT10);
            seq_q   <= SEQ_OFF_EXC;
          end
        end
        SEQ_OFF_EXC: begin
          if (timer_q == 16'h0) begin
            excite_q <= 1'b0; // [RULE7]
            seq_q    <= SEQ_OFF;
          end
        end
        default: begin
          excite_q <= 1'b0;
          brake_q  <= 1'b0;
          seq_q    <= SEQ_OFF;
        end
      endcase
    end
  end

  // Threshold monitors, refreshed every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rot_q    <= 1'b0;
      zclamp_q <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      rot_q    <= motorSpeed > rotThresh_q; // [RULE2] [RULE11]
      zclamp_q <= excite_q &&
                  absVal(32'(speedCommand)) < {16'h0, zeroClamp_q}; // [RULE1]
      ovf_q    <= absVal(positionDeviation) > ovfLimit_q; // [RULE3]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seqPrev_q <= SEQ_OFF;
    end else begin
      seqPrev_q <= seq_q;
    end
  end

  assign irqEvents[IRQ_OVF]      = (absVal(positionDeviation) > ovfLimit_q) && !ovf_q;
  assign irqEvents[IRQ_ROT]      = (motorSpeed > rotThresh_q) && !rot_q;
  assign irqEvents[IRQ_ON_DONE]  = (seq_q == SEQ_RUN) && (seqPrev_q != SEQ_RUN);
  assign irqEvents[IRQ_OFF_DONE] = (seq_q == SEQ_OFF) && (seqPrev_q != SEQ_OFF);

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~((regWrite && regAddr == ADDR_IRQ_STAT) ?
                   regWdata[IRQ_BITS-1:0] : '0)) | irqEvents;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CTRL:       rdata_q <= {30'h0, ctrl_q};
        ADDR_ZCLAMP:     rdata_q <= {16'h0, zeroClamp_q};
        ADDR_ROT_TH:     rdata_q <= {16'h0, rotThresh_q};
        ADDR_OVF_LIM:    rdata_q <= ovfLimit_q;
        ADDR_SON_WAIT:   rdata_q <= 32'(servoOnWait_q);
        ADDR_SOFF_WAIT:  rdata_q <= {16'h0, servoOffWait_q};
        ADDR_BRK_SPD:    rdata_q <= {16'h0, brakeSpeed_q};
        ADDR_BRK_WAIT:   rdata_q <= {16'h0, brakeWait_q};
        ADDR_ALLOC1:     rdata_q <= allocStaged_q;
        ADDR_ALLOC1_ACT: rdata_q <= allocActive_q;
        ADDR_STATUS:     rdata_q <= {26'h0, servoOn, ovf_q, zclamp_q, rot_q, brake_q,
                                     excite_q};
        ADDR_IRQ_STAT:   rdata_q <= {28'h0, irqStat_q};
        ADDR_IRQ_MASK:   rdata_q <= {28'h0, irqMask_q};
        default:         rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign regRdata            = rdata_q;
  assign motorExcite         = excite_q;
  assign holding_brake_out   = brake_q;
  assign rotation_detect_out = rot_q;
  assign zeroClampActive     = zclamp_q;
  assign overflowAlarm       = ovf_q;
  assign activeAllocation    = allocActive_q;
  assign irq                 = |(irqStat_q & irqMask_q);

endmodule // sbs_servo_brake_sequencer

// ### test/sbs_motor_model.sv
`timescale 1ns/1ps
module sbs_motor_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        motorExcite,
  input  wire logic        holding_brake_out,
  input  wire logic [15:0] targetSpeed,
  output logic      [15:0] motorSpeed
);
  // Excited motor ramps to target; engaged brake stops a free motor fast
  always_ff @(posedge clk) begin
    if (rst) begin
      motorSpeed <= 16'h0;
    end else if (motorExcite && motorSpeed < targetSpeed) begin
      motorSpeed <= motorSpeed + 16'h1;
    end else if (motorExcite && motorSpeed > targetSpeed) begin
      motorSpeed <= motorSpeed - 16'h1;
    end else if (!motorExcite && !holding_brake_out) begin
      motorSpeed <= (motorSpeed > 16'h4) ? motorSpeed - 16'h4 : 16'h0;
    end else if (!motorExcite && motorSpeed != 16'h0) begin
      motorSpeed <= motorSpeed - 16'h1;
    end
  end
endmodule // sbs_motor_model

// ### test/sbs_servo_brake_sequencer_sva.sv
`timescale 1ns/1ps
module sbs_checker
  import sbs_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [7:0]         regAddr,
  input wire logic [31:0]        regWdata,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [31:0]        regRdata,
  input wire logic [3:0]         inputPorts,
  input wire logic signed [15:0] speedCommand,
  input wire logic [15:0]        motorSpeed,
  input wire logic signed [31:0] positionDeviation,
  input wire logic               motorExcite,
  input wire logic               holding_brake_out,
  input wire logic               rotation_detect_out,
  input wire logic               zeroClampActive,
  input wire logic               overflowAlarm,
  input wire logic [31:0]        activeAllocation,
  input wire logic               irq
);
  logic [1:0]         ctrl_q;
  logic [31:0]        zeroClamp_q;
  logic [31:0]        rotTh_q;
  logic [31:0]        ovfLim_q;
  logic signed [31:0] sonWait_q;
  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return (v < 0) ? -v : v;
  endfunction
  // Shadow copies of the settings, clamped like the design except the servo-on wait, kept as written
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q      <= 2'h0;
      zeroClamp_q <= RST_ZCLAMP;
      rotTh_q     <= RST_ROT_TH;
      ovfLim_q    <= RST_OVF_LIM;
      sonWait_q   <= 32'sh0;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_CTRL:     ctrl_q <= regWdata[1:0];
        ADDR_ZCLAMP:   zeroClamp_q <= (regWdata > MAX_ROT_TH) ? MAX_ROT_TH : regWdata;
        ADDR_ROT_TH:   rotTh_q <= (regWdata > MAX_ROT_TH) ? MAX_ROT_TH : regWdata;
        ADDR_OVF_LIM:  ovfLim_q <= (regWdata < MIN_OVF_LIM) ? MIN_OVF_LIM :
                                   (regWdata > MAX_OVF_LIM) ? MAX_OVF_LIM : regWdata;
        ADDR_SON_WAIT: sonWait_q <= regWdata;
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_excRise;
    $rose(motorExcite);
  endsequence
  sequence s_brkRise;
    $rose(holding_brake_out);
  endsequence
  property p_rot;
    !$past(rst) |-> rotation_detect_out == $past(32'(motorSpeed) > rotTh_q);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotation output off");
  property p_ovf;
    !$past(rst) |-> overflowAlarm == $past(mag(positionDeviation) > ovfLim_q);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow alarm off");
  property p_zcl;
    zeroClampActive |-> $past(mag(speedCommand) < zeroClamp_q);
  endproperty
  a_zcl: assert property (p_zcl)
    else $error("clamp without slow command");
  property p_alloc;
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> $stable(activeAllocation);
  endproperty
  a_alloc: assert property (p_alloc)
    else $error("allocation changed in run");
  property p_onPos;
    (ctrl_q[CTRL_BRAKE_FN] && sonWait_q > 0) ##0 s_excRise |-> $past(holding_brake_out);
  endproperty
  a_onPos: assert property (p_onPos)
    else $error("excited before brake output");
  property p_onNeg;
    (ctrl_q[CTRL_BRAKE_FN] && sonWait_q < 0) ##0 s_brkRise |-> $past(motorExcite);
  endproperty
  a_onNeg: assert property (p_onNeg)
    else $error("brake output before excitation");
  property p_fnOff;
    (!ctrl_q[CTRL_BRAKE_FN] && !$past(rst) && $stable(ctrl_q))
      |-> motorExcite == $past(ctrl_q[CTRL_SERVO_ON] | inputPorts[0]);
  endproperty
  a_fnOff: assert property (p_fnOff)
    else $error("excitation not direct");
  property p_offOrd;
    ctrl_q[CTRL_BRAKE_FN] ##0 $fell(motorExcite) |-> !holding_brake_out;
  endproperty
  a_offOrd: assert property (p_offOrd)
    else $error("excitation removed before brake");
endmodule // sbs_checker

bind sbs_servo_brake_sequencer sbs_checker #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .inputPorts(inputPorts),
  .speedCommand(speedCommand), .motorSpeed(motorSpeed),
  .positionDeviation(positionDeviation), .motorExcite(motorExcite),
  .holding_brake_out(holding_brake_out), .rotation_detect_out(rotation_detect_out),
  .zeroClampActive(zeroClampActive), .overflowAlarm(overflowAlarm),
  .activeAllocation(activeAllocation), .irq(irq)
);

// ### test/tb_servo_brake_sequencer.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin nErrors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(c, n) for (k = 0; k < (n) && !(c); k++) cyc(1);
module tb_servo_brake_sequencer
  import sbs_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [7:0]         regAddr = 8'h0;
  logic [31:0]        regWdata = 32'h0;
  logic               regWrite = 1'b0;
  logic               regRead = 1'b0;
  logic [31:0]        regRdata;
  logic [31:0]        activeAllocation;
  logic [3:0]         inputPorts = 4'h0;
  logic signed [15:0] speedCommand = 16'sh64;
  logic [15:0]        motorSpeed;
  logic [15:0]        targetSpeed = 16'h0;
  logic signed [31:0] positionDeviation = 32'sh0;
  logic               motorExcite, holding_brake_out, rotation_detect_out;
  logic               zeroClampActive, overflowAlarm, irq;
  int                 nErrors = 0;
  int                 comparisons = 0;
  logic [7:0]         ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                                  8'h20, 8'h24, 8'h28, 8'h30, 8'h3c};
  logic [31:0]        re [13] = '{32'h0, 32'ha, 32'h14, 32'h1, 32'h0, 32'h0, 32'h64, 32'h32,
                                  32'h03020100, 32'h03020100, 32'h0, 32'h0, 32'h0};
  logic [7:0]         ca [10] = '{8'h08, 8'h0c, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h18, 8'h1c,
                                  8'h1c, 8'h20};
  logic [31:0]        cd [10] = '{32'hbb9, 32'h0, 32'h05000001, 32'hfffff82f, 32'h1f5,
                                  32'h9, 32'h65, 32'h9, 32'h65, 32'h1d1d1d1d};
  logic [31:0]        ce [10] = '{32'hbb8, 32'h1, 32'h05000000, 32'hfffff830, 32'h1f4,
                                  32'ha, 32'h64, 32'ha, 32'h64, 32'h1c1c1c1c};
  always #25 clk = ~clk;
  sbs_servo_brake_sequencer #(.MS_CYCLES(4)) i_dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .inputPorts(inputPorts),
    .speedCommand(speedCommand), .motorSpeed(motorSpeed),
    .positionDeviation(positionDeviation), .motorExcite(motorExcite),
    .holding_brake_out(holding_brake_out), .rotation_detect_out(rotation_detect_out),
    .zeroClampActive(zeroClampActive), .overflowAlarm(overflowAlarm),
    .activeAllocation(activeAllocation), .irq(irq));
  sbs_motor_model i_motor (.clk(clk), .rst(rst), .motorExcite(motorExcite),
    .holding_brake_out(holding_brake_out), .targetSpeed(targetSpeed),
    .motorSpeed(motorSpeed));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask
  task automatic give_verdict;
    if (nErrors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #250_000;
    nErrors++;
    give_verdict();
  end
  initial begin
    int k;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 13; k++) begin
      rdchk(ra[k], re[k]);
    end
    for (k = 0; k < 10; k++) begin
      wr(ca[k], cd[k]);
      rdchk(ca[k], ce[k]);
    end
    rdchk(ADDR_ALLOC1_ACT, 32'h03020100);
    `CHK("activeAllocation", 32'h03020100, activeAllocation)
    wr(ADDR_ROT_TH, 32'h14);
    wr(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_OVF_LIM, 32'h64);
    inputPorts <= 4'he;
    targetSpeed <= 16'h14;
    cyc(3);
    `CHK("motorExcite", 1'b0, motorExcite)
    inputPorts <= 4'h1;
    cyc(2);
    `CHK("motorExcite", 1'b1, motorExcite)
    cyc(30);
    `CHK("rotation", 1'b0, rotation_detect_out)
    targetSpeed <= 16'h15;
    cyc(4);
    `CHK("rotation", 1'b1, rotation_detect_out)
    `CHK("irq", 1'b1, irq)
    wr(ADDR_IRQ_STAT, 32'hf);
    cyc(1);
    `CHK("irq", 1'b0, irq)
    targetSpeed <= 16'h14;
    cyc(4);
    `CHK("rotation", 1'b0, rotation_detect_out)
    wr(ADDR_IRQ_MASK, 32'h0);
    targetSpeed <= 16'h15;
    cyc(4);
    `CHK("irq", 1'b0, irq)
    rdchk(ADDR_IRQ_STAT, 32'h2);
    speedCommand <= 16'sh5;
    cyc(3);
    `CHK("zeroClamp", 1'b1, zeroClampActive)
    speedCommand <= -16'sh5;
    cyc(3);
    `CHK("zeroClamp", 1'b1, zeroClampActive)
    speedCommand <= 16'sha;
    cyc(3);
    `CHK("zeroClamp", 1'b0, zeroClampActive)
    positionDeviation <= 32'sh64;
    cyc(3);
    `CHK("overflow", 1'b0, overflowAlarm)
    positionDeviation <= -32'sh65;
    cyc(3);
    `CHK("overflow", 1'b1, overflowAlarm)
    rdchk(ADDR_STATUS, 32'h35);
    rdchk(ADDR_IRQ_STAT, 32'h3);
    inputPorts <= 4'h0;
    cyc(2);
    `CHK("motorExcite", 1'b0, motorExcite)
    wr(ADDR_SOFF_WAIT, 32'h1);
    wr(ADDR_BRK_WAIT, 32'ha);
    wr(ADDR_SON_WAIT, 32'h3);
    targetSpeed <= 16'h32;
    wr(ADDR_CTRL, 32'h3);
    cyc(2);
    `CHK("brake", 1'b1, holding_brake_out)
    cyc(3);
    `CHK("motorExcite", 1'b0, motorExcite)
    `WAITFOR(motorExcite, 20)
    `CHK("motorExcite", 1'b1, motorExcite)
    cyc(60);
    wr(ADDR_CTRL, 32'h2);
    cyc(3);
    `CHK("brake", 1'b0, holding_brake_out)
    cyc(20);
    `CHK("motorExcite", 1'b1, motorExcite)
    `WAITFOR(!motorExcite, 40)
    `CHK("motorExcite", 1'b0, motorExcite)
    wr(ADDR_BRK_SPD, 32'ha);
    targetSpeed <= 16'hc8;
    wr(ADDR_CTRL, 32'h3);
    cyc(240);
    wr(ADDR_CTRL, 32'h2);
    cyc(300);
    `CHK("brake", 1'b1, holding_brake_out)
    `WAITFOR(!holding_brake_out, 120)
    `CHK("brake", 1'b0, holding_brake_out)
    `WAITFOR(!motorExcite, 60)
    `CHK("motorExcite", 1'b0, motorExcite)
    targetSpeed <= 16'h0;
    wr(ADDR_SON_WAIT, 32'hfffffffe);
    wr(ADDR_CTRL, 32'h3);
    cyc(3);
    `CHK("motorExcite", 1'b1, motorExcite)
    `CHK("brake", 1'b0, holding_brake_out)
    `WAITFOR(holding_brake_out, 16)
    `CHK("brake", 1'b1, holding_brake_out)
    give_verdict();
  end
endmodule // tb_servo_brake_sequencer
